// file: core/erb_pkg.sv
package erb_pkg;

  localparam int TOTAL_BITS = 2048;
  localparam int ADDR_W     = 11;
  localparam int DATA_W     = 8;
  localparam int BUS_AW     = 4;
  localparam int CNT_W      = 12;

  typedef enum logic [1:0] {
    SHAPE_256X8 = 2'h0,
    SHAPE_512X4 = 2'h1,
    SHAPE_1KX2  = 2'h2,
    SHAPE_2KX1  = 2'h3
  } erb_shape_t;

  typedef enum logic [1:0] {
    MODE_RAM  = 2'h0,
    MODE_ROM  = 2'h1,
    MODE_DUAL = 2'h2,
    MODE_FIFO = 2'h3
  } erb_mode_t;

  typedef enum logic [1:0] {
    CE_DIV    = 2'h0,
    CE_GLOBAL = 2'h1,
    CE_LOCAL  = 2'h2,
    CE_OFF    = 2'h3
  } erb_ce_src_t;

  localparam logic [BUS_AW-1:0] OFF_CTRL      = 4'h0;
  localparam logic [BUS_AW-1:0] OFF_STATUS    = 4'h4;
  localparam logic [BUS_AW-1:0] OFF_INIT_ADDR = 4'h8;
  localparam logic [BUS_AW-1:0] OFF_INIT_DATA = 4'hC;

  localparam int CTL_SHAPE  = 0;
  localparam int CTL_MODE   = 2;
  localparam int CTL_REG_D  = 4;
  localparam int CTL_REG_A  = 5;
  localparam int CTL_REG_O  = 6;
  localparam int CTL_WE_GLB = 7;
  localparam int CTL_ROW_EN = 8;
  localparam int CTL_COL_EN = 9;
  localparam int CTL_CE_IN  = 10;
  localparam int CTL_CE_OUT = 12;
  localparam int CTL_DIV_IN = 16;
  localparam int CTL_DIV_OU = 24;

  localparam logic [31:0]       CTRL_RESET   = 32'h0000_0370;
  localparam logic [31:0]       BUS_ZERO     = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  WORDS_MIN    = 12'h100;
  localparam logic [1:0]        LG_WIDTH_MAX = 2'h3;

  // Fastest grade ceilings for 256x8 with registered paths; one cycle at CLK_MHZ is slower
  localparam int READ_MAX_MHZ  = 172;
  localparam int WRITE_MAX_MHZ = 106;
  localparam int CLK_MHZ       = 50;

  function automatic logic [CNT_W-1:0] erbWords(input erb_shape_t s);
    return WORDS_MIN << s;
  endfunction : erbWords

endpackage : erb_pkg

// file: core/erb_ce_div.sv
`timescale 1ns/1ps
`default_nettype none
// Turns ref_clk into a one-cycle enable every div+1 cycles
module erb_ce_div #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstN,
  // Control and enable
  input  wire logic [W-1:0] div,
  output logic              tick
);

  logic [W-1:0] cntQ;
  logic [W-1:0] cntD;

  assign tick = (cntQ >= div);

  always_comb begin
    cntD = tick ? '0 : W'(cntQ + 1'b1);
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) cntQ <= '0;
    else       cntQ <= cntD;
  end

endmodule : erb_ce_div
`default_nettype wire

// file: core/erb_bit_array.sv
`timescale 1ns/1ps
`default_nettype none
// Flat bit store; word width follows the shape, words are packed bit-contiguous
module erb_bit_array import erb_pkg::*; (
  // Clock
  input  wire logic              clk,
  // Shape
  input  wire erb_shape_t        shape,
  // Write port
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrWord,
  input  wire logic [DATA_W-1:0] wrData,
  // Read port
  input  wire logic [ADDR_W-1:0] rdWord,
  output logic      [DATA_W-1:0] rdData
);

  logic [TOTAL_BITS-1:0] memQ;
  logic [TOTAL_BITS-1:0] memD;
  logic [1:0]            lgW;
  logic [3:0]            width;
  logic [ADDR_W-1:0]     wrBase;
  logic [ADDR_W-1:0]     rdBase;

  assign lgW    = LG_WIDTH_MAX - shape;
  assign width  = 4'h1 << lgW;
  assign wrBase = ADDR_W'(wrWord << lgW);
  assign rdBase = ADDR_W'(rdWord << lgW);

  // Read sees only the stored state, so a same-cycle write returns old data
  always_comb begin
    memD   = memQ;
    rdData = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (4'(i) < width) begin
        rdData[i] = memQ[ADDR_W'(rdBase + ADDR_W'(i))];
        if (wrEn) memD[ADDR_W'(wrBase + ADDR_W'(i))] = wrData[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    memQ <= memD;
  end

endmodule : erb_bit_array
`default_nettype wire

// file: core/erb_embedded_ram_block.sv
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - 2048 storage bits serve as single-port RAM, ROM, dual-port RAM or FIFO.
// - RAM shape is 256x8, 512x4, 1024x2 or 2048x1.
// - Block makes its own write strobe on the clock; user gives address, data, request.
// - Data input, output, and address with write request are each optionally registered.
// - Input-side and output-side registers run on separate clock enables.
// - Write request from global or local source; enables from divider, global or local.
// - Equal-depth blocks share address and write control to form wider words.
// - Blocks cascade in depth up to 2048 words by select, with no extra latency.
// - Logic use loads a fixed pattern at setup, then reads it as a lookup table.
// - Each output bit drives two row and two column channels at once.
// - 256x8 registered reads to 172 MHz and writes to 106 MHz in fastest grade.
module erb_embedded_ram_block import erb_pkg::*; #(
  parameter int                CASC_W     = 3,
  parameter logic [CASC_W-1:0] CASC_INDEX = '0
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  // Avalon-MM slave
  input  wire logic [BUS_AW-1:0] avAddress,
  input  wire logic              avRead,
  input  wire logic              avWrite,
  input  wire logic [31:0]       avWriteData,
  input  wire logic [3:0]        avByteEnable,
  output logic      [31:0]       avReadData,
  output logic                   avWaitRequest,
  // Fabric write side
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic              wrReq,
  input  wire logic              wrReqGlobal,
  // Fabric read side
  input  wire logic [ADDR_W-1:0] rdAddr,
  input  wire logic              rdReq,
  // Enables and cascade select
  input  wire logic              ceGlobal,
  input  wire logic              ceLocal,
  input  wire logic [CASC_W-1:0] cascSel,
  // Outputs to routing
  output logic      [DATA_W-1:0] rowData0,
  output logic      [DATA_W-1:0] rowData1,
  output logic      [DATA_W-1:0] colData0,
  output logic      [DATA_W-1:0] colData1,
  output logic                   fifoFull,
  output logic                   fifoEmpty
);

  logic [1:0] rstSyncQ;
  logic       rstN;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) rstSyncQ <= 2'h0;
    else        rstSyncQ <= {rstSyncQ[0], 1'b1};
  end
  assign rstN = rstSyncQ[1];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstN);

  // Control fields
  logic [31:0]       ctrlQ, ctrlD;
  erb_shape_t        shape;
  erb_mode_t         mode;
  erb_ce_src_t       ceInSrc, ceOutSrc;
  logic              regData, regAddr, regOut, weGlobal, rowEn, colEn;
  logic [CNT_W-1:0]  words;
  logic [ADDR_W-1:0] mask;

  assign shape    = erb_shape_t'(ctrlQ[CTL_SHAPE +: 2]);
  assign mode     = erb_mode_t'(ctrlQ[CTL_MODE +: 2]);
  assign regData  = ctrlQ[CTL_REG_D];
  assign regAddr  = ctrlQ[CTL_REG_A];
  assign regOut   = ctrlQ[CTL_REG_O];
  assign weGlobal = ctrlQ[CTL_WE_GLB];
  assign rowEn    = ctrlQ[CTL_ROW_EN];
  assign colEn    = ctrlQ[CTL_COL_EN];
  assign ceInSrc  = erb_ce_src_t'(ctrlQ[CTL_CE_IN +: 2]);
  assign ceOutSrc = erb_ce_src_t'(ctrlQ[CTL_CE_OUT +: 2]);
  assign words    = erbWords(shape);
  assign mask     = ADDR_W'(words - 1'b1);

  // Clock enables for the two sides
  logic divInTick, divOutTick, ceIn, ceOut;

  erb_ce_div #(.W(8)) uDivIn (
    .clk  (ref_clk),
    .rstN (rstN),
    .div  (ctrlQ[CTL_DIV_IN +: 8]),
    .tick (divInTick)
  );

  erb_ce_div #(.W(8)) uDivOut (
    .clk  (ref_clk),
    .rstN (rstN),
    .div  (ctrlQ[CTL_DIV_OU +: 8]),
    .tick (divOutTick)
  );

  function automatic logic pickCe(input erb_ce_src_t s, input logic d, g, l);
    unique case (s)
      CE_DIV:    return d;
      CE_GLOBAL: return g;
      CE_LOCAL:  return l;
      CE_OFF:    return 1'b0;
    endcase
  endfunction : pickCe

  assign ceIn  = pickCe(ceInSrc, divInTick, ceGlobal, ceLocal);
  assign ceOut = pickCe(ceOutSrc, divOutTick, ceGlobal, ceLocal);

  // Input-side registers
  logic [DATA_W-1:0] inDataQ, inDataD, dataEff;
  logic [ADDR_W-1:0] inAddrQ, inAddrD, inRdAddrQ, inRdAddrD, addrEff, rdAddrEff;
  logic              inWeQ, inWeD, weSrc, weEff, selected;

  assign selected  = (cascSel == CASC_INDEX);
  assign weSrc     = weGlobal ? wrReqGlobal : wrReq;
  assign dataEff   = regData ? inDataQ : wrData;
  assign addrEff   = regAddr ? inAddrQ : wrAddr;
  assign rdAddrEff = regAddr ? inRdAddrQ : rdAddr;
  assign weEff     = regAddr ? inWeQ : weSrc;

  always_comb begin
    inDataD   = inDataQ;
    inAddrD   = inAddrQ;
    inRdAddrD = inRdAddrQ;
    inWeD     = inWeQ;
    if (ceIn) begin
      inDataD   = wrData;
      inAddrD   = wrAddr;
      inRdAddrD = rdAddr;
      inWeD     = weSrc;
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      inDataQ   <= '0;
      inAddrQ   <= '0;
      inRdAddrQ <= '0;
      inWeQ     <= 1'b0;
    end else begin
      inDataQ   <= inDataD;
      inAddrQ   <= inAddrD;
      inRdAddrQ <= inRdAddrD;
      inWeQ     <= inWeD;
    end
  end

  // Bus handshake: one wait cycle, then the access completes
  logic              busReq, ackQ, ackD, busWr, ctrlWr, initWr;
  logic [31:0]       rdDataQ, rdDataD;
  logic [ADDR_W-1:0] initAddrQ, initAddrD;

  assign busReq        = avRead | avWrite;
  assign avWaitRequest = busReq & ~ackQ;
  assign ackD          = busReq & ~ackQ;
  assign busWr         = avWrite & ackQ;
  assign ctrlWr        = busWr & (avAddress == OFF_CTRL);
  assign initWr        = busWr & (avAddress == OFF_INIT_DATA) & avByteEnable[0];
  assign avReadData    = rdDataQ;

  // FIFO pointers and the write strobe
  logic [ADDR_W-1:0] wrPtrQ, wrPtrD, rdPtrQ, rdPtrD, memWord, rdWord;
  logic [CNT_W-1:0]  cntQ, cntD;
  logic              isFifo, userWe, push, pop, memWe;
  logic [DATA_W-1:0] memData, rdComb;

  assign isFifo    = (mode == MODE_FIFO);
  assign fifoFull  = isFifo & (cntQ == words);
  assign fifoEmpty = ~isFifo | (cntQ == '0);
  // Strobe lives only in the enable cycle, so the user never shapes its timing
  assign userWe    = weEff & ceIn & selected & (mode != MODE_ROM)
                     & ~(isFifo & fifoFull);
  assign push      = userWe & isFifo;
  assign pop       = isFifo & rdReq & ceOut & selected & ~fifoEmpty;
  // Pattern load takes priority; a same-cycle user write loses its data, but in FIFO mode it still advances wrPtrQ and the count
  assign memWe     = initWr | userWe;
  assign memWord   = initWr ? initAddrQ : (isFifo ? wrPtrQ : (addrEff & mask));
  assign memData   = initWr ? avWriteData[DATA_W-1:0] : dataEff;

  always_comb begin
    unique case (mode)
      MODE_FIFO: rdWord = rdPtrQ;
      MODE_DUAL: rdWord = rdAddrEff & mask;
      default:   rdWord = addrEff & mask;
    endcase
  end

  always_comb begin
    wrPtrD = wrPtrQ;
    rdPtrD = rdPtrQ;
    cntD   = cntQ;
    if (ctrlWr) begin
      wrPtrD = '0;
      rdPtrD = '0;
      cntD   = '0;
    end else begin
      if (push) wrPtrD = ADDR_W'(wrPtrQ + 1'b1) & mask;
      if (pop)  rdPtrD = ADDR_W'(rdPtrQ + 1'b1) & mask;
      cntD = CNT_W'(cntQ + CNT_W'(push) - CNT_W'(pop));
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
      cntQ   <= '0;
    end else begin
      wrPtrQ <= wrPtrD;
      rdPtrQ <= rdPtrD;
      cntQ   <= cntD;
    end
  end

  erb_bit_array uArray (
    .clk    (ref_clk),
    .shape  (shape),
    .wrEn   (memWe),
    .wrWord (memWord),
    .wrData (memData),
    .rdWord (rdWord),
    .rdData (rdComb)
  );

  // Output side; unselected blocks drive zeros so cascaded outputs can be ORed
  logic [DATA_W-1:0] outQ, outD, outEff, rowQ, rowD, colQ, colD;

  assign outEff = selected ? (regOut ? outQ : rdComb) : '0;

  always_comb begin
    outD = ceOut ? rdComb : outQ;
    rowD = rowEn ? outEff : '0;
    colD = colEn ? outEff : '0;
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      outQ <= '0;
      rowQ <= '0;
      colQ <= '0;
    end else begin
      outQ <= outD;
      rowQ <= rowD;
      colQ <= colD;
    end
  end

  assign rowData0 = rowQ;
  assign rowData1 = rowQ;
  assign colData0 = colQ;
  assign colData1 = colQ;

  // Register file
  always_comb begin
    ctrlD     = ctrlQ;
    initAddrD = initAddrQ;
    rdDataD   = rdDataQ;
    if (ctrlWr) begin
      for (int b = 0; b < 4; b++) begin
        if (avByteEnable[b]) ctrlD[b*8 +: 8] = avWriteData[b*8 +: 8];
      end
    end
    if (busWr && avAddress == OFF_INIT_ADDR) initAddrD = avWriteData[ADDR_W-1:0] & mask;
    if (initWr) initAddrD = ADDR_W'(initAddrQ + 1'b1) & mask;
    if (avRead && !ackQ) begin
      unique case (avAddress)
        OFF_CTRL:      rdDataD = ctrlQ;
        OFF_STATUS:    rdDataD = {8'h00, outQ, 1'b0, selected, fifoEmpty, fifoFull, cntQ};
        OFF_INIT_ADDR: rdDataD = 32'(initAddrQ);
        default:       rdDataD = BUS_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      ctrlQ     <= CTRL_RESET;
      initAddrQ <= '0;
      rdDataQ   <= BUS_ZERO;
      ackQ      <= 1'b0;
    end else begin
      ctrlQ     <= ctrlD;
      initAddrQ <= initAddrD;
      rdDataQ   <= rdDataD;
      ackQ      <= ackD;
    end
  end

  a_fifo_count_bound: assert property (cntQ <= words)
    else $error("fifo count beyond depth of shape");

  a_fifo_full_hold: assert property (fifoFull && !pop && !ctrlWr |=> $stable(cntQ))
    else $error("fifo count moved while full");

  a_rom_no_write: assert property (mode == MODE_ROM && !initWr |-> !memWe)
    else $error("user write reached array in lookup mode");

  a_strobe_on_enable: assert property (memWe && !initWr |-> ceIn && selected)
    else $error("write strobe outside input enable");

  a_dual_old_data: assert property (mode == MODE_DUAL && memWe && !initWr
    && rdWord == memWord && !$past(memWe) && $stable(rdWord) |-> $stable(rdComb))
    else $error("dual port read did not return old contents");

  a_bus_one_wait: assert property (busReq && !ackQ |=> !avWaitRequest)
    else $error("bus access not answered after one wait cycle");

  a_cascade_quiet: assert property (!selected |=> rowQ == '0 && colQ == '0)
    else $error("unselected block drove its outputs");

  a_input_reg_hold: assert property (!ceIn |=> $stable(inDataQ) && $stable(inWeQ))
    else $error("input register changed without enable");

  a_out_reg_hold: assert property (!ceOut |=> $stable(outQ))
    else $error("output register changed without enable");

  a_row_col_match: assert property (rowEn && colEn |=> rowData0 == colData1)
    else $error("row and column channels disagree");

endmodule : erb_embedded_ram_block
`default_nettype wire

// file: testbench/erb_fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
// User logic on the fabric side; data lines go stale once a write is taken
module erb_fabric_model import erb_pkg::*; (
  // Clock
  input  wire logic              clk,
  // Command from bench
  input  wire logic              go,
  input  wire logic              doWr,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] data,
  // Fabric write side
  output logic      [ADDR_W-1:0] wrAddr = '0,
  output logic      [DATA_W-1:0] wrData = '0,
  output logic                   wrReq  = 1'b0
);
  // Address is held after the request so single-port modes can read it back
  always @(posedge clk) begin
    if (go) begin
      wrAddr <= addr;
      wrData <= data;
      wrReq  <= doWr;
    end else if (wrReq) begin
      wrReq  <= 1'b0;
      wrData <= ~wrData;
    end
  end
endmodule : erb_fabric_model
`default_nettype wire

// file: testbench/erb_embedded_config_ram_block_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module erb_embedded_config_ram_block_tb_top import erb_pkg::*;;
  logic              ref_clk, rst_b, avRead, avWrite, avWaitRequest;
  logic [3:0]        avAddress;
  logic [31:0]       avWriteData, avReadData, q;
  logic [ADDR_W-1:0] wrAddr, rdAddr, fAddr;
  logic [DATA_W-1:0] wrData, fData, row0, row1, col0, col1;
  logic              wrReq, go, fWr, rdReq, fifoFull, fifoEmpty, ceGlb, weGlb;
  logic [2:0]        cascSel;
  int                num_errors, check_count;

  erb_fabric_model i_fab (.clk(ref_clk), .go(go), .doWr(fWr), .addr(fAddr), .data(fData),
    .wrAddr(wrAddr), .wrData(wrData), .wrReq(wrReq));

  erb_embedded_ram_block i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .avAddress(avAddress),
    .avRead(avRead), .avWrite(avWrite), .avWriteData(avWriteData), .avByteEnable(4'hF),
    .avReadData(avReadData), .avWaitRequest(avWaitRequest), .wrAddr(wrAddr),
    .wrData(wrData), .wrReq(wrReq), .wrReqGlobal(weGlb), .rdAddr(rdAddr), .rdReq(rdReq),
    .ceGlobal(ceGlb), .ceLocal(1'b0), .cascSel(cascSel), .rowData0(row0), .rowData1(row1),
    .colData0(col0), .colData1(col1), .fifoFull(fifoFull), .fifoEmpty(fifoEmpty));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Request held until waitrequest is sampled low at a rising edge; data taken there
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avWrite     <= w;
    avRead      <= ~w;
    avAddress   <= a;
    avWriteData <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avWaitRequest !== 1'b0 && n < 50);
    q = avReadData;
    avWrite <= 1'b0;
    avRead  <= 1'b0;
    if (n >= 50) check(32'h1, 32'h0);
  endtask : bus

  task automatic fab(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic w);
    @(posedge ref_clk);
    go    <= 1'b1;
    fAddr <= a;
    fData <= d;
    fWr   <= w;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : fab

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic t_regs();
    bus(1'b0, OFF_CTRL, BUS_ZERO);
    check(q, 32'h0000_0370);
    // Word 0 is read back into STATUS through the output register; give it a known value
    fab(11'h0, 8'h00, 1'b1);
    cyc(2);
    bus(1'b0, OFF_STATUS, BUS_ZERO);
    check(q, 32'h0000_6000);
    bus(1'b0, 4'h2, BUS_ZERO);
    check(q, BUS_ZERO);
  endtask : t_regs

  task automatic t_shapes();
    logic [7:0]  m;
    logic [10:0] top;
    for (int s = 0; s < 4; s++) begin
      m   = (8'h01 << (8 >> s)) - 8'h01;
      top = 11'((256 << s) - 1);
      bus(1'b1, OFF_CTRL, 32'h300 | s);
      fab(top, 8'hA5, 1'b1);
      cyc(2);
      check({24'h0, row0}, {24'h0, 8'hA5 & m});
      check({row1, col0, col1}, {3{8'hA5 & m}});
    end
  endtask : t_shapes

  // Fixed product pattern loaded at setup; fabric writes must not disturb it
  task automatic t_rom();
    bus(1'b1, OFF_CTRL, 32'h304);
    bus(1'b1, OFF_INIT_ADDR, 32'h23);
    bus(1'b1, OFF_INIT_DATA, 32'h6);
    bus(1'b1, OFF_INIT_DATA, 32'h8);
    fab(11'h23, 8'hFF, 1'b1);
    cyc(2);
    check({24'h0, row0}, 32'h6);
    fab(11'h24, 8'h00, 1'b0);
    cyc(2);
    check({24'h0, row0}, 32'h8);
  endtask : t_rom

  task automatic t_dual();
    bus(1'b1, OFF_CTRL, 32'h308);
    rdAddr <= 11'h10;
    bus(1'b1, OFF_INIT_ADDR, 32'h10);
    bus(1'b1, OFF_INIT_DATA, 32'h0);
    fab(11'h10, 8'h11, 1'b1);
    cyc(2);
    check({24'h0, row0}, 32'h11);
    fab(11'h10, 8'h22, 1'b1);
    check({24'h0, row0}, 32'h11);
    cyc(1);
    check({24'h0, row0}, 32'h22);
  endtask : t_dual

  // Deselected block refuses writes and drives zeros
  task automatic t_casc();
    @(posedge ref_clk);
    cascSel <= 3'h1;
    fab(11'h10, 8'h33, 1'b1);
    cyc(2);
    check({24'h0, row0}, 32'h0);
    @(posedge ref_clk);
    cascSel <= 3'h0;
    cyc(2);
    check({24'h0, row0}, 32'h22);
  endtask : t_casc

  // Global write request on the global input enable; local request ignored
  task automatic t_ce();
    bus(1'b1, OFF_CTRL, 32'h780);
    ceGlb <= 1'b1;
    fab(11'h40, 8'h55, 1'b0);
    @(posedge ref_clk);
    weGlb <= 1'b1;
    @(posedge ref_clk);
    weGlb <= 1'b0;
    cyc(2);
    check({24'h0, row0}, 32'h55);
    fab(11'h40, 8'h66, 1'b1);
    cyc(2);
    check({24'h0, row0}, 32'h55);
    @(posedge ref_clk);
    ceGlb <= 1'b0;
    weGlb <= 1'b1;
    @(posedge ref_clk);
    weGlb <= 1'b0;
    cyc(2);
    check({24'h0, row0}, 32'h55);
  endtask : t_ce

  task automatic t_fifo();
    bus(1'b1, OFF_CTRL, 32'h30C);
    for (int i = 0; i < 256; i++) fab(11'h0, 8'(i) ^ 8'h5A, 1'b1);
    check({31'h0, fifoFull}, 32'h1);
    fab(11'h0, 8'h00, 1'b1);
    bus(1'b0, OFF_STATUS, BUS_ZERO);
    check({20'h0, q[11:0]}, 32'h100);
    // Outputs show the head ahead of the pop
    check({24'h0, row0}, 32'h5A);
    @(posedge ref_clk);
    rdReq <= 1'b1;
    @(posedge ref_clk);
    rdReq <= 1'b0;
    cyc(2);
    check({24'h0, row0}, 32'h5B);
    @(posedge ref_clk);
    rdReq <= 1'b1;
    repeat (255) @(posedge ref_clk);
    rdReq <= 1'b0;
    cyc(2);
    check({30'h0, fifoFull, fifoEmpty}, 32'h1);
  endtask : t_fifo

  initial begin
    num_errors  = 0;
    check_count = 0;
    rst_b       = 1'b0;
    {avRead, avWrite, go, fWr, rdReq, ceGlb, weGlb} = '0;
    {avAddress, avWriteData, rdAddr, fAddr, fData, cascSel} = '0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs();
    t_shapes();
    t_rom();
    t_dual();
    t_casc();
    t_ce();
    t_fifo();
    print_verdict();
  end

  // Whole run is about 1,200 cycles
  initial begin
    #200us;
    num_errors++;
    print_verdict();
  end
endmodule : erb_embedded_config_ram_block_tb_top
`default_nettype wire
